// File: core/dss_pkg.sv
// Constants, types and field layout of the dual synchronous serial port.
// Function
// - Four-wire full-duplex, shift out and in together.
// - Software selects master or slave role.
// - Works on multi-master or multi-slave shared bus.
// - Detect collision when masters start together.
// - Master serial clock at most sysclk/2.
// - Word 8 or 16 bits, MSB first.
// - Software picks active level of select.
// - Two independent ports, own pins and registers.
package dss_pkg;

    localparam int NPORT = 2;
    localparam int ADDR_W = 8;

    ////////////////////////////////////////////////////////////////////////
    // Register map, per port; bit PORT_BIT of the address picks the port
    localparam int PORT_BIT = 5;
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_TX = 5'h04;
    localparam logic [4:0] OFS_RX = 5'h08;
    localparam logic [4:0] OFS_STAT = 5'h0C;
    localparam logic [4:0] OFS_MASK = 5'h10;

    // Control fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_MASTER = 1;
    localparam int CTRL_LEN16 = 2;
    localparam int CTRL_SSEL_HI = 3;
    localparam int CTRL_DIV_LSB = 8;
    localparam int DIV_W = 8;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // Status and mask fields
    localparam int EV_W = 2;
    localparam int STAT_DONE = 0;
    localparam int STAT_COLL = 1;
    localparam int STAT_BUSY = 2;
    localparam logic [EV_W-1:0] STAT_RESET = 2'h0;
    localparam logic [EV_W-1:0] MASK_RESET = 2'h0;
    localparam logic [15:0] TX_RESET = 16'h0000;

    // Word lengths in bits
    localparam logic [4:0] LEN8 = 5'd8;
    localparam logic [4:0] LEN16 = 5'd16;

    ////////////////////////////////////////////////////////////////////////
    // Timing: the shortest master half period is one system clock
    localparam int SYS_CLK_MHZ = 250;
    localparam logic [DIV_W-1:0] DIV_MIN = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MASTER = 2'b01,
        ST_SLAVE = 2'b10
    } dss_state_e;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ssel;
    } dss_pin_in_s;

    typedef struct packed {
        logic sck_o;
        logic sck_oe_n;
        logic mosi_o;
        logic mosi_oe_n;
        logic miso_o;
        logic miso_oe_n;
        logic ssel_o;
        logic ssel_oe_n;
    } dss_pin_out_s;

endpackage : dss_pkg

// File: core/dss_sync.sv
// Two-flop synchroniser for pin inputs.
`timescale 1ns/100ps
`default_nettype none
module dss_sync #(
    parameter int W = 4
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : dss_sync
`default_nettype wire

// File: core/dss_top.sv
// Dual synchronous serial port with APB register access.
`timescale 1ns/100ps
`default_nettype none
module dss_top (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dss_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire dss_pkg::dss_pin_in_s [dss_pkg::NPORT-1:0] pin_in,
    output var dss_pkg::dss_pin_out_s [dss_pkg::NPORT-1:0] pin_out
);
    import dss_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    logic [4:0] ofs;
    logic port_sel;
    logic mapped;
    logic access;
    logic [31:0] rd_word [NPORT];
    logic [NPORT-1:0] irq_p;

    assign ofs = paddr[4:0];
    assign port_sel = paddr[PORT_BIT];
    assign access = psel & penable;
    // Zero wait states
    assign pready = 1'b1;
    assign mapped = (paddr[ADDR_W-1:PORT_BIT+1] == '0) &&
                    (ofs == OFS_CTRL || ofs == OFS_TX || ofs == OFS_RX ||
                     ofs == OFS_STAT || ofs == OFS_MASK);
    assign pslverr = access & ~mapped;
    assign prdata = (access && !pwrite && mapped) ? rd_word[port_sel] : 32'h0000_0000;
    assign irq = |irq_p;

    function automatic logic [15:0] align_word(input logic [15:0] d, input logic len16);
        align_word = len16 ? d : {d[7:0], 8'h00};
    endfunction : align_word

    ////////////////////////////////////////////////////////////////////////
    // Port instances
    // two ports
    for (genvar i = 0; i < NPORT; i++) begin : g_port
        dss_pin_in_s pin_s;
        logic [15:0] ctrl_r;
        logic [15:0] tx_r;
        logic [15:0] rx_r;
        logic [15:0] sh_r;
        logic [15:0] rsh_r;
        logic [EV_W-1:0] stat_r;
        logic [EV_W-1:0] mask_r;
        logic [4:0] bit_r;
        logic [DIV_W-1:0] div_r;
        logic sck_r;
        logic sck_d_r;
        dss_state_e st_r;
        logic en;
        logic mst;
        logic len16;
        logic [4:0] len;
        logic sel_act;
        logic hit;
        logic wr_ctrl;
        logic wr_tx;
        logic wr_mask;
        logic rd_stat;
        logic tick;
        logic m_rise;
        logic m_fall;
        logic s_rise;
        logic s_fall;
        logic start_m;
        logic coll;
        logic done;
        logic [EV_W-1:0] ev;
        logic [1:0] samp_r;
        logic end_m_r;
        logic [15:0] rsh_cur;

        dss_sync #(
            .W(4)
        ) u_sync (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .d(pin_in[i]),
            .q(pin_s)
        );

        assign hit = access & mapped & (port_sel == 1'(i));
        assign wr_ctrl = hit & pwrite & (ofs == OFS_CTRL);
        assign wr_tx = hit & pwrite & (ofs == OFS_TX);
        assign wr_mask = hit & pwrite & (ofs == OFS_MASK);
        assign rd_stat = hit & ~pwrite & (ofs == OFS_STAT);

        assign en = ctrl_r[CTRL_EN];
        assign mst = ctrl_r[CTRL_MASTER];
        assign len16 = ctrl_r[CTRL_LEN16];
        assign len = len16 ? LEN16 : LEN8;
        assign sel_act = (pin_s.ssel == ctrl_r[CTRL_SSEL_HI]);

        assign tick = (div_r == ctrl_r[CTRL_DIV_LSB +: DIV_W]);
        assign m_rise = (st_r == ST_MASTER) & tick & ~sck_r;
        assign m_fall = (st_r == ST_MASTER) & tick & sck_r;
        // edges found on the synchronised clock
        assign s_rise = pin_s.sck & ~sck_d_r;
        assign s_fall = ~pin_s.sck & sck_d_r;

        assign start_m = wr_tx & en & mst & (st_r == ST_IDLE);
        // select seen while starting or driving
        assign coll = en & mst & sel_act & (start_m | (st_r == ST_MASTER));
        assign done = end_m_r |
                      ((st_r == ST_SLAVE) & sel_act & s_rise & (bit_r + 5'd1 == len));
        assign rsh_cur = samp_r[1] ? {rsh_r[14:0], pin_s.miso} : rsh_r;
        assign ev = {coll, done};

        ////////////////////////////////////////////////////////////////////
        // Software registers
        always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
                ctrl_r <= CTRL_RESET;
                mask_r <= MASK_RESET;
                tx_r <= TX_RESET;
            end else begin
                if (wr_ctrl) begin
                    ctrl_r <= pwdata[15:0];
                end
                if (wr_mask) begin
                    mask_r <= pwdata[EV_W-1:0];
                end
                if (wr_tx) begin
                    tx_r <= pwdata[15:0];
                end
            end
        end

        // sticky flags, a new event wins over the read clear
        always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
                stat_r <= STAT_RESET;
            end else begin
                stat_r <= (stat_r & ~{EV_W{rd_stat}}) | ev;
            end
        end

        assign irq_p[i] = |(stat_r & mask_r);

        always_comb begin
            rd_word[i] = 32'h0000_0000;
            unique case (ofs)
                OFS_CTRL: rd_word[i] = {16'h0000, ctrl_r};
                OFS_TX: rd_word[i] = {16'h0000, tx_r};
                OFS_RX: rd_word[i] = {16'h0000, rx_r};
                OFS_STAT: rd_word[i] = {29'h0000_0000, (st_r != ST_IDLE), stat_r};
                OFS_MASK: rd_word[i] = {30'h0000_0000, mask_r};
                default: rd_word[i] = 32'h0000_0000;
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // Master clock generator
        always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
                div_r <= DIV_MIN;
                sck_r <= 1'b0;
            end else if (st_r != ST_MASTER || coll) begin
                div_r <= DIV_MIN;
                sck_r <= 1'b0;
            end else if (tick) begin
                div_r <= DIV_MIN;
                sck_r <= ~sck_r;
            end else begin
                div_r <= div_r + 8'h01;
            end
        end

        // returning data lags two sync flops, so sample two cycles after the rise
        always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
                samp_r <= 2'b00;
                end_m_r <= 1'b0;
            end else if (coll) begin
                samp_r <= 2'b00;
                end_m_r <= 1'b0;
            end else begin
                samp_r <= {samp_r[0], m_rise};
                // Word ends one cycle after the last fall, once the late sample is in
                end_m_r <= m_fall & en & (bit_r == len);
            end
        end

        // Edge history of the synchronised serial clock
        always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
                sck_d_r <= 1'b0;
            end else begin
                sck_d_r <= pin_s.sck;
            end
        end

        ////////////////////////////////////////////////////////////////////
        // Shift engine
        always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
                st_r <= ST_IDLE;
                sh_r <= 16'h0000;
                rsh_r <= 16'h0000;
                bit_r <= 5'd0;
            end else begin
                if (samp_r[1]) begin
                    rsh_r <= {rsh_r[14:0], pin_s.miso};
                end
                unique case (st_r)
                    ST_IDLE: begin
                        bit_r <= 5'd0;
                        if (start_m && !coll) begin
                            st_r <= ST_MASTER;
                            sh_r <= align_word(pwdata[15:0], len16);
                        end else if (en && !mst && sel_act) begin
                            st_r <= ST_SLAVE;
                            sh_r <= align_word(tx_r, len16);
                        end
                    end
                    ST_MASTER: begin
                        // yield the bus to another master
                        if (coll || !en) begin
                            st_r <= ST_IDLE;
                        // sample in on rise, shift out on fall
                        end else if (m_rise) begin
                            bit_r <= bit_r + 5'd1;
                        end else if (m_fall) begin
                            if (bit_r == len) begin
                                st_r <= ST_IDLE;
                            end else begin
                                sh_r <= {sh_r[14:0], 1'b0};
                            end
                        end
                    end
                    ST_SLAVE: begin
                        if (!sel_act || !en || mst) begin
                            st_r <= ST_IDLE;
                        end else if (s_rise) begin
                            rsh_r <= {rsh_r[14:0], pin_s.mosi};
                            if (bit_r + 5'd1 == len) begin
                                bit_r <= 5'd0;
                                sh_r <= align_word(tx_r, len16);
                            end else begin
                                bit_r <= bit_r + 5'd1;
                            end
                        end else if (s_fall && bit_r != 5'd0) begin
                            sh_r <= {sh_r[14:0], 1'b0};
                        end
                    end
                    default: st_r <= ST_IDLE;
                endcase
            end
        end

        // Received word, low-aligned; last bit comes straight from the pin in slave mode and for a master at the shortest half period
        always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
                rx_r <= 16'h0000;
            end else if (end_m_r) begin
                rx_r <= len16 ? rsh_cur : {8'h00, rsh_cur[7:0]};
            end else if (done) begin
                rx_r <= len16 ? {rsh_r[14:0], pin_s.mosi} : {8'h00, rsh_r[6:0], pin_s.mosi};
            end
        end

        ////////////////////////////////////////////////////////////////////
        // Pin drive; lines are released whenever not in a transfer
        always_comb begin
            pin_out[i].sck_o = sck_r;
            pin_out[i].sck_oe_n = (st_r != ST_MASTER);
            pin_out[i].mosi_o = sh_r[15];
            pin_out[i].mosi_oe_n = (st_r != ST_MASTER);
            pin_out[i].ssel_o = ctrl_r[CTRL_SSEL_HI];
            pin_out[i].ssel_oe_n = (st_r != ST_MASTER);
            pin_out[i].miso_o = sh_r[15];
            // slave data out only while selected
            pin_out[i].miso_oe_n = (st_r != ST_SLAVE);
        end
    end

endmodule : dss_top
`default_nettype wire

// File: dv/dss_checker.sv
// Port-level assertions for the dual serial port.
`timescale 1ns/100ps
`default_nettype none
module dss_checker (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dss_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire dss_pkg::dss_pin_out_s [dss_pkg::NPORT-1:0] pin_out
);
    import dss_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic [4:0] cnt_r;
    // Rising serial clocks in the current master word
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= 5'h00;
        end else if (pin_out[0].sck_oe_n) begin
            cnt_r <= 5'h00;
        end else if ($rose(pin_out[0].sck_o)) begin
            cnt_r <= cnt_r + 5'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    oe_tie_a: assert property (pin_out[0].sck_oe_n == pin_out[0].mosi_oe_n && pin_out[0].sck_oe_n == pin_out[0].ssel_oe_n)
        else $error("master lines not enabled together");
    sck_idle_a: assert property ($fell(pin_out[0].sck_oe_n) |-> !pin_out[0].sck_o)
        else $error("clock not low at start");
    mosi_hold_a: assert property (!pin_out[0].mosi_oe_n && $past(!pin_out[0].mosi_oe_n) && $changed(pin_out[0].mosi_o) |-> $fell(pin_out[0].sck_o))
        else $error("data moved off a falling clock");
    bit_cnt_a: assert property ($rose(pin_out[0].sck_o) && !pin_out[0].sck_oe_n |-> cnt_r < 5'h10)
        else $error("more than sixteen bits");
    start_src_a: assert property ($fell(pin_out[0].sck_oe_n) |-> $past(psel && penable && pwrite && paddr == 8'h04))
        else $error("master start without data write");
    port_iso_a: assert property (psel && penable && pwrite && paddr == 8'h24 && pin_out[0].sck_oe_n |=> pin_out[0].sck_oe_n)
        else $error("other port started this one");
    role_excl_a: assert property (!pin_out[0].miso_oe_n |-> pin_out[0].sck_oe_n)
        else $error("master and slave drive together");
    unmap_a: assert property (psel && penable && paddr[7:6] != 2'h0 |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    rdy_a: assert property (psel && penable |-> pready)
        else $error("access not answered");
    cover property ($fell(pin_out[0].sck_oe_n));
    cover property ($rose(irq));
    cover property ($fell(pin_out[0].miso_oe_n));
endmodule : dss_checker
bind dss_top dss_checker i_chk (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
    .pslverr, .irq, .pin_out);
`default_nettype wire

// File: dv/dss_peer.sv
// Behavioural far-side serial device: slave or master.
`timescale 1ns/100ps
`default_nettype none
module dss_peer (
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic sel_n,
    output logic p_sck,
    output logic p_mosi,
    output logic p_miso,
    output logic p_ssel
);
    logic [15:0] s_tx = 16'h0000;
    logic [15:0] s_rx = 16'h0000;
    logic [15:0] m_rx = 16'h0000;
    logic [15:0] sh = 16'h0000;
    initial p_sck = 1'b0;
    initial p_mosi = 1'b0;
    initial p_ssel = 1'b1;
    always @(negedge sel_n) sh = s_tx;
    // sample on rise, shift on fall
    always @(posedge sck) if (!sel_n) s_rx <= {s_rx[14:0], mosi};
    always @(negedge sck) if (!sel_n) sh <= {sh[14:0], 1'b0};
    // Released line shows the inverse, never a stale bit
    assign p_miso = sel_n ? ~sh[15] : sh[15];
    // link clock 80 ns, MSB first
    task automatic xfer(input logic [15:0] w, input int n);
        // Steps land on system clock edges, so pins move by non-blocking assignment
        p_ssel <= 1'b0;
        p_mosi <= w[15];
        repeat (n) begin
            #40 p_sck <= 1'b1;
            m_rx = {m_rx[14:0], miso};
            #40 p_sck <= 1'b0;
            w = w << 1;
            p_mosi <= w[15];
        end
        #40 p_ssel <= 1'b1;
        p_mosi <= ~p_mosi;
    endtask : xfer
endmodule : dss_peer
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the dual serial port.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import dss_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq, er;
    logic p_sck, p_mosi, p_miso, p_ssel;
    dss_pin_in_s [NPORT-1:0] pin_in;
    dss_pin_out_s [NPORT-1:0] pin_out;
    int bad_count = 0;
    int n_tests = 0;
    int wk;
    always #2 sys_clk = ~sys_clk;
    // Own select output is never looped back
    assign pin_in[0] = '{sck: pin_out[0].sck_oe_n ? p_sck : pin_out[0].sck_o,
        mosi: pin_out[0].mosi_oe_n ? p_mosi : pin_out[0].mosi_o,
        miso: pin_out[0].miso_oe_n ? p_miso : pin_out[0].miso_o, ssel: p_ssel};
    assign pin_in[1] = '{sck: 1'b0, mosi: 1'b0, miso: 1'b1, ssel: 1'b1};
    dss_top i_dut (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .irq, .pin_in, .pin_out);
    dss_peer i_peer (.sck(pin_in[0].sck), .mosi(pin_in[0].mosi), .miso(pin_in[0].miso),
        .sel_n(pin_out[0].ssel_oe_n | pin_out[0].ssel_o), .p_sck, .p_mosi, .p_miso, .p_ssel);
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("Checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            close_out;
        end
    endtask : apb
    task automatic wait_irq;
        wk = 0;
        while (irq !== 1'b1 && wk < 2000) begin
            @(posedge sys_clk);
            wk++;
        end
        if (irq !== 1'b1) begin
            bad_count++;
            close_out;
        end
    endtask : wait_irq
    task automatic sc_regs;
        apb(0, 8'h00, 0); chk(rd, 0);
        apb(0, 8'h10, 0); chk(rd, 0);
        apb(1, 8'h20, 32'h0000_0003);
        apb(1, 8'h24, 32'h0000_0055);
        apb(0, 8'h00, 0); chk(rd, 0);
        apb(0, 8'h20, 0); chk(rd, 3);
        apb(0, 8'h40, 0); chk({er, rd[30:0]}, 32'h8000_0000);
        // Second port's own transfer has ended by now; its input line idles high
        repeat (8) @(posedge sys_clk);
        apb(0, 8'h2C, 0); chk(rd, 1);
        apb(0, 8'h28, 0); chk(rd, 32'h0000_00FF);
    endtask : sc_regs
    // Word exchange as master; timing from write edge to irq seen
    task automatic sc_master(input logic [15:0] c, input logic [15:0] tx, input logic [15:0] rep,
        input logic [15:0] erx, input logic [15:0] ept, input int et);
        i_peer.s_tx = rep;
        i_peer.s_rx = 16'h0000;
        apb(1, 8'h10, 1);
        apb(1, 8'h00, {16'h0000, c});
        apb(1, 8'h04, {16'h0000, tx});
        wait_irq;
        chk(wk, et);
        apb(0, 8'h0C, 0); chk(rd, 1);
        apb(0, 8'h08, 0); chk(rd, erx);
        chk(i_peer.s_rx, ept);
        chk(irq, 0);
    endtask : sc_master
    task automatic sc_slave;
        apb(1, 8'h10, 0);
        apb(1, 8'h00, 1);
        apb(1, 8'h04, 32'h0000_005A);
        i_peer.xfer(16'hC300, 8);
        chk(i_peer.m_rx[7:0], 8'h5A);
        chk(irq, 0);
        apb(0, 8'h08, 0); chk(rd, 32'h0000_00C3);
        apb(0, 8'h0C, 0); chk(rd, 1);
        apb(1, 8'h00, 9);
        i_peer.xfer(16'hFF00, 8);
        apb(0, 8'h08, 0); chk(rd, 32'h0000_00C3);
        apb(0, 8'h0C, 0); chk(rd, 32'h0000_0004);
    endtask : sc_slave
    // Other master already selecting us at start
    task automatic sc_coll;
        i_peer.p_ssel <= 1'b0;
        apb(1, 8'h10, 2);
        apb(1, 8'h00, 3);
        apb(1, 8'h04, 32'h0000_0055);
        wait_irq;
        chk(pin_out[0].sck_oe_n, 1);
        apb(0, 8'h0C, 0); chk(rd[1:0], 2'b10);
        i_peer.p_ssel <= 1'b1;
        apb(0, 8'h0C, 0); chk(rd, 0);
        chk(irq, 0);
    endtask : sc_coll
    initial begin
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        sc_regs;
        sc_master(16'h0003, 16'h003C, 16'hA500, 16'h00A5, 16'h003C, 18);
        sc_master(16'h0107, 16'h1234, 16'hBEEF, 16'hBEEF, 16'h1234, 66);
        sc_slave;
        sc_coll;
        close_out;
    end
endmodule : tb_top
`default_nettype wire
